//--- inc/baud_pkg.sv
// Constants, field layout and types shared by the baud rate generator
package baud_pkg;

    // Bus word and register offsets (byte addresses)
    typedef logic [31:0] word_t;
    localparam logic [7:0] OFS_TX_CTRL = 8'h00;
    localparam logic [7:0] OFS_RX_CTRL = 8'h04;
    localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h0C;
    localparam logic [7:0] OFS_DIV_LOW = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Field positions inside the control registers
    localparam int TX_MASTER_BIT = 7;
    localparam int TX_SYNC_BIT = 4;
    localparam int TX_HS_BIT = 2;
    localparam int RX_ENABLE_BIT = 7;
    localparam int BC_RX_INV_BIT = 5;
    localparam int BC_CLK_POL_BIT = 4;
    localparam int BC_WIDE_BIT = 3;

    // Status register layout
    localparam int ST_COUNT_LSB = 0;
    localparam int ST_OS_LSB = 16;
    localparam int ST_LEVEL_BIT = 24;

    // Values after reset
    localparam logic [7:0] TX_CTRL_RST = 8'h00;
    localparam logic [7:0] RX_CTRL_RST = 8'h00;
    localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [7:0] DIV_LOW_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [5:0] OS_RST = 6'h00;

    // Writable bits and bits that read as constant one
    localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
    localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
    localparam logic [7:0] BAUD_CTRL_WMASK = 8'hBB;
    localparam logic [7:0] TX_CTRL_ONES = 8'h02;
    localparam logic [7:0] BAUD_CTRL_ONES = 8'h40;

    // Oversampling: last count per bit and first voting sample
    localparam logic [5:0] OS_LAST_64 = 6'h3F;
    localparam logic [5:0] OS_LAST_16 = 6'h0F;
    localparam logic [5:0] OS_LAST_4 = 6'h03;
    localparam logic [5:0] OS_MID_64 = 6'h1F;
    localparam logic [5:0] OS_MID_16 = 6'h07;
    localparam logic [5:0] OS_MID_4 = 6'h01;
    localparam logic [5:0] OS_VOTE_SPAN = 6'h02;

    // Bus codes
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Divider modes
    typedef enum logic [1:0] {
        MODE_ASYNC64,
        MODE_ASYNC16,
        MODE_ASYNC4,
        MODE_SYNC4
    } mode_t;

endpackage

//--- inc/sample_if.sv
// Carrier between the sampling control and the majority voter
`timescale 1ns/1ns
interface sample_if;
    logic strobe;
    logic data;
    logic last;
    logic level;
    logic valid;
    modport ctl (output strobe, output data, output last,
                 input level, input valid);
    modport voter (input strobe, input data, input last,
                   output level, output valid);
endinterface

//--- hdl/majority_vote.sv
// Three-sample majority voter for the receive pin level
`timescale 1ns/1ns
module majority_vote (
    input wire logic clk,
    input wire logic rst_b,
    sample_if.voter smp
);
    import baud_pkg::*;

    typedef struct packed {
        logic [1:0] hist;
        logic level;
        logic valid;
    } vote_t;

    vote_t v_r;
    vote_t v_nxt;

    // Shift samples in; decide on the third of each group
    always_comb begin
        v_nxt = v_r;
        v_nxt.valid = 1'b0;
        if (smp.strobe) begin
            v_nxt.hist = {v_r.hist[0], smp.data};
            if (smp.last) begin
                v_nxt.level = (v_r.hist[1] & v_r.hist[0]) |
                              (v_r.hist[1] & smp.data) |
                              (v_r.hist[0] & smp.data); // [RL3]
                v_nxt.valid = 1'b1;
            end
        end
    end

    // Line idles high, so the level starts high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            v_r <= '{hist: 2'h3, level: 1'b1, valid: 1'b0};
        end else begin
            v_r <= v_nxt;
        end
    end

    assign smp.level = v_r.level;
    assign smp.valid = v_r.valid;
endmodule

//--- hdl/baud_gen.sv
// Baud rate generator: bus registers, divider, sampling control
`timescale 1ns/1ns
// What this block does
// RL1: All timing counts device clock cycles, so clock changes scale the rate.
// RL2: Software reprograms the divisor after a clock frequency change.
// RL3: Receive level is the majority of three pin samples.
// RL4: Async, 8-bit, low speed: rate is clock over 64 times (n+1).
// RL5: Async, 8-bit, high speed: rate is clock over 16 times (n+1).
// RL6: Async, 16-bit, low speed: rate is clock over 16 times (n+1).
// RL7: Sync: shift clock is clock over 4 times (n+1); speed select ignored.
// RL8: Divisor n is high register as upper byte, low as lower byte.
// RL9: High register supplies the upper divisor byte in 16-bit mode.
// RL10: Async, 16-bit, high speed: rate is clock over 4 times (n+1).
// RL11: Free-running down-counter reloads from divisor at zero, one tick each.
// RL12: Writing either divisor register restarts the divider at once.
// RL13: Software avoids divisor zero or one in synchronous mode.
// RL14: Wide select clear, its reset value, uses only the low register.
module baud_gen (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire baud_pkg::word_t HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire baud_pkg::word_t HWDATA,
    input wire logic HREADY,
    output baud_pkg::word_t HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RECEIVE_PIN,
    output logic SAMPLE_TICK,
    output logic BAUD_TICK,
    output logic SHIFT_CLK,
    output logic RX_LEVEL,
    output logic RX_LEVEL_VALID
);
    import baud_pkg::*;

    // All state of the block outside the majority voter
    typedef struct packed {
        logic [7:0] tx_ctrl;
        logic [7:0] rx_ctrl;
        logic [7:0] baud_ctrl;
        logic [7:0] div_high;
        logic [7:0] div_low;
        logic [15:0] count;
        logic [5:0] os_cnt;
        mode_t mode;
        logic sample_tick;
        logic baud_tick;
        logic shift_clk;
        logic rx_meta;
        logic rx_sync;
        logic strobe;
        logic strobe_data;
        logic strobe_last;
        logic wr_pend;
        logic [7:0] wr_ofs;
        word_t hrdata;
        logic hready;
        logic hresp;
    } state_t;

    localparam state_t RST_STATE = '{
        tx_ctrl: TX_CTRL_RST,
        rx_ctrl: RX_CTRL_RST,
        baud_ctrl: BAUD_CTRL_RST,
        div_high: DIV_HIGH_RST,
        div_low: DIV_LOW_RST,
        count: COUNT_RST,
        os_cnt: OS_RST,
        mode: MODE_ASYNC64,
        rx_meta: 1'b1,
        rx_sync: 1'b1,
        hready: 1'b1,
        hresp: HRESP_OKAY,
        default: '0
    };

    state_t s_r;
    state_t s_nxt;

    sample_if smp ();

    // Voting window has to fit inside one bit for every ratio
    if (OS_MID_64 + OS_VOTE_SPAN > OS_LAST_64 ||
        OS_MID_16 + OS_VOTE_SPAN > OS_LAST_16 ||
        OS_MID_4 + OS_VOTE_SPAN > OS_LAST_4) begin : g_bad_window
        $error("voting window runs past the end of a bit");
    end

    // Status fields must not overlap or leave the bus word
    if (ST_OS_LSB < ST_COUNT_LSB + 16 ||
        ST_LEVEL_BIT < ST_OS_LSB + 6 ||
        ST_LEVEL_BIT > 31) begin : g_bad_status
        $error("status fields overlap or leave the word");
    end

    // Divisor seen by the counter; high byte only in wide mode
    function automatic logic [15:0] divisor_of(input state_t st);
        logic [15:0] d;
        d = {8'h00, st.div_low}; // [RL14]
        if (st.baud_ctrl[BC_WIDE_BIT]) begin
            d = {st.div_high, st.div_low}; // [RL8] [RL9]
        end
        return d;
    endfunction

    // Oversampling mode from sync, wide and speed selects
    function automatic mode_t mode_of(input state_t st);
        mode_t m;
        m = MODE_ASYNC64; // [RL4]
        if (st.tx_ctrl[TX_SYNC_BIT]) begin
            m = MODE_SYNC4; // [RL7]
        end else begin
            case ({st.baud_ctrl[BC_WIDE_BIT], st.tx_ctrl[TX_HS_BIT]})
                2'b00: m = MODE_ASYNC64; // [RL4]
                2'b01: m = MODE_ASYNC16; // [RL5]
                2'b10: m = MODE_ASYNC16; // [RL6]
                2'b11: m = MODE_ASYNC4; // [RL10]
                default: m = MODE_ASYNC64;
            endcase
        end
        return m;
    endfunction

    // Last oversample count of one bit for each mode
    function automatic logic [5:0] os_last_of(input mode_t m);
        logic [5:0] l;
        case (m)
            MODE_ASYNC64: l = OS_LAST_64;
            MODE_ASYNC16: l = OS_LAST_16;
            MODE_ASYNC4: l = OS_LAST_4;
            MODE_SYNC4: l = OS_LAST_4;
            default: l = OS_LAST_64;
        endcase
        return l;
    endfunction

    // First of the three voting samples, just before mid-bit
    function automatic logic [5:0] os_mid_of(input mode_t m);
        logic [5:0] p;
        case (m)
            MODE_ASYNC64: p = OS_MID_64;
            MODE_ASYNC16: p = OS_MID_16;
            MODE_ASYNC4: p = OS_MID_4;
            MODE_SYNC4: p = OS_MID_4;
            default: p = OS_MID_64;
        endcase
        return p;
    endfunction

    // Read view of every register; unmapped offsets read zero
    function automatic word_t read_word(input state_t st,
                                        input logic [7:0] ofs,
                                        input logic level);
        word_t w;
        w = 32'h0000_0000;
        case (ofs)
            OFS_TX_CTRL: w[7:0] = st.tx_ctrl | TX_CTRL_ONES;
            OFS_RX_CTRL: w[7:0] = st.rx_ctrl;
            OFS_BAUD_CTRL: w[7:0] = st.baud_ctrl | BAUD_CTRL_ONES;
            OFS_DIV_HIGH: w[7:0] = st.div_high;
            OFS_DIV_LOW: w[7:0] = st.div_low;
            OFS_STATUS: begin
                w[ST_COUNT_LSB +: 16] = st.count;
                w[ST_OS_LSB +: 6] = st.os_cnt;
                w[ST_LEVEL_BIT] = level;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Next-state logic for registers, divider and sampling
    always_comb begin
        logic take;
        logic div_write;
        logic tick;
        logic async_mode;
        logic sync_master;
        logic [15:0] div;
        logic [5:0] last;
        logic [5:0] mid;

        s_nxt = s_r;
        take = 1'b0;
        div_write = 1'b0;
        tick = 1'b0;
        async_mode = 1'b0;
        sync_master = 1'b0;
        div = 16'h0000;
        last = 6'h00;
        mid = 6'h00;

        // One-cycle pulses fall back each cycle
        s_nxt.sample_tick = 1'b0;
        s_nxt.baud_tick = 1'b0;
        s_nxt.strobe = 1'b0;
        s_nxt.strobe_last = 1'b0;

        // Two-stage synchroniser for the receive pin
        s_nxt.rx_meta = RECEIVE_PIN;
        s_nxt.rx_sync = s_r.rx_meta;

        // Data phase of a write taken last cycle
        if (s_r.wr_pend) begin
            case (s_r.wr_ofs)
                OFS_TX_CTRL: begin
                    s_nxt.tx_ctrl = HWDATA[7:0] & TX_CTRL_WMASK;
                end
                OFS_RX_CTRL: begin
                    s_nxt.rx_ctrl = HWDATA[7:0] & RX_CTRL_WMASK;
                end
                OFS_BAUD_CTRL: begin
                    s_nxt.baud_ctrl = HWDATA[7:0] & BAUD_CTRL_WMASK;
                end
                OFS_DIV_HIGH: begin
                    s_nxt.div_high = HWDATA[7:0];
                    div_write = 1'b1;
                end
                OFS_DIV_LOW: begin
                    s_nxt.div_low = HWDATA[7:0];
                    div_write = 1'b1;
                end
                default: begin
                    div_write = 1'b0;
                end
            endcase
        end

        // Mode and divisor follow the freshly written values
        s_nxt.mode = mode_of(s_nxt);
        div = divisor_of(s_nxt);
        last = os_last_of(s_nxt.mode);
        mid = os_mid_of(s_nxt.mode);
        async_mode = !s_nxt.tx_ctrl[TX_SYNC_BIT];
        sync_master = s_nxt.tx_ctrl[TX_SYNC_BIT] &&
                      s_nxt.tx_ctrl[TX_MASTER_BIT] &&
                      s_nxt.rx_ctrl[RX_ENABLE_BIT];

        // Device-clock down-counter, one tick per reload at zero
        if (div_write) begin
            s_nxt.count = div; // [RL12]
            s_nxt.os_cnt = OS_RST; // [RL12]
        end else if (s_r.count == 16'h0000) begin
            s_nxt.count = div; // [RL11] [RL1]
            tick = 1'b1; // [RL11]
        end else begin
            s_nxt.count = s_r.count - 16'h0001; // [RL1]
        end

        // A mode change restarts the bit unless a tick falls in the same cycle
        if (s_nxt.mode != s_r.mode) begin
            s_nxt.os_cnt = OS_RST;
        end

        // Oversample counter: one bit per 64, 16 or 4 ticks
        if (tick) begin
            s_nxt.sample_tick = 1'b1;
            if (s_r.os_cnt >= last) begin
                s_nxt.os_cnt = OS_RST;
                s_nxt.baud_tick = 1'b1; // [RL4] [RL5] [RL6] [RL10]
            end else begin
                s_nxt.os_cnt = s_r.os_cnt + 6'h01;
            end
        end

        // Shift clock: toggles every second tick in sync master
        if (!sync_master) begin
            s_nxt.shift_clk = s_nxt.baud_ctrl[BC_CLK_POL_BIT];
        end else if (tick && s_r.os_cnt[0]) begin
            s_nxt.shift_clk = !s_r.shift_clk; // [RL7]
        end

        // Three strobes around mid-bit feed the voter
        if (tick && async_mode && s_nxt.rx_ctrl[RX_ENABLE_BIT] &&
            s_r.os_cnt >= mid && s_r.os_cnt <= mid + OS_VOTE_SPAN) begin
            s_nxt.strobe = 1'b1; // [RL3]
            s_nxt.strobe_data = s_r.rx_sync ^
                                s_nxt.baud_ctrl[BC_RX_INV_BIT];
            s_nxt.strobe_last = (s_r.os_cnt == mid + OS_VOTE_SPAN);
        end

        // Address phase: take the request, answer with no wait
        take = HSEL && HTRANS[1] && HREADY;
        s_nxt.wr_pend = take && HWRITE && (HSIZE == HSIZE_WORD);
        s_nxt.wr_ofs = HADDR[7:0];
        if (take && !HWRITE) begin
            s_nxt.hrdata = read_word(s_nxt, HADDR[7:0], smp.level);
        end
        s_nxt.hready = 1'b1;
        s_nxt.hresp = HRESP_OKAY;
    end

    // State register with synchronous active-low reset
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Strobes to the voter
    assign smp.strobe = s_r.strobe;
    assign smp.data = s_r.strobe_data;
    assign smp.last = s_r.strobe_last;

    majority_vote u_vote (
        .clk(CLOCK),
        .rst_b(RST_B),
        .smp(smp)
    );

    // Outputs straight from flip-flops
    assign HRDATA = s_r.hrdata;
    assign HREADYOUT = s_r.hready;
    assign HRESP = s_r.hresp;
    assign SAMPLE_TICK = s_r.sample_tick;
    assign BAUD_TICK = s_r.baud_tick;
    assign SHIFT_CLK = s_r.shift_clk;
    assign RX_LEVEL = smp.level;
    assign RX_LEVEL_VALID = smp.valid;
endmodule

//--- test/serial_station.sv
// Remote serial station driving the receive pin
`timescale 1ns/1ns
module serial_station (
    input wire logic clk,
    input wire logic level,
    input wire logic glitch_en,
    output logic pin
);
    logic [3:0] gap_r = 4'h0;
    // Spacing of one-cycle line glitches, never two within three cycles
    always_ff @(posedge clk) begin
        gap_r <= (gap_r == 4'hC) ? 4'h0 : gap_r + 4'h1;
    end
    assign pin = level ^ (glitch_en && gap_r == 4'h0);
endmodule

//--- test/baud_gen_asserts.sv
// Port checker for the baud rate generator
`timescale 1ns/1ns
module baud_gen_asserts
    import baud_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire baud_pkg::word_t HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire baud_pkg::word_t HWDATA,
    input wire logic HREADY,
    input wire baud_pkg::word_t HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic RECEIVE_PIN,
    input wire logic SAMPLE_TICK,
    input wire logic BAUD_TICK,
    input wire logic SHIFT_CLK,
    input wire logic RX_LEVEL,
    input wire logic RX_LEVEL_VALID
);
    logic pend_r, ok_r, sync_r, hs_r, wide_r, pol_r, wr_div, wr_ctl;
    logic [7:0] ofs_r, hi_r, lo_r;
    logic [17:0] cnt_r;
    logic [5:0] stk_r;
    logic [15:0] n;
    logic [6:0] r;
    // Divisor and oversampling ratio as software programmed them
    assign n = wide_r ? {hi_r, lo_r} : {8'h00, lo_r};
    assign r = (sync_r || (wide_r && hs_r)) ? 7'h04
        : (wide_r || hs_r) ? 7'h10 : 7'h40;
    assign wr_div = pend_r && (ofs_r == OFS_DIV_LOW || ofs_r == OFS_DIV_HIGH);
    assign wr_ctl = pend_r && (ofs_r == OFS_TX_CTRL || ofs_r == OFS_BAUD_CTRL);
    // Shadow of bus writes; counts restart on divisor writes
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            {pend_r, ok_r, sync_r, hs_r, wide_r, pol_r} <= 6'h00;
            {hi_r, lo_r, ofs_r} <= 24'h00_0000;
            cnt_r <= 18'h0_0000;
            stk_r <= 6'h00;
        end else begin
            pend_r <= HSEL && HTRANS[1] && HREADY && HWRITE
                && HSIZE == HSIZE_WORD;
            ofs_r <= HADDR[7:0];
            if (pend_r && ofs_r == OFS_TX_CTRL) begin
                {sync_r, hs_r} <= {HWDATA[TX_SYNC_BIT], HWDATA[TX_HS_BIT]};
            end
            if (pend_r && ofs_r == OFS_BAUD_CTRL) begin
                wide_r <= HWDATA[BC_WIDE_BIT];
                pol_r <= HWDATA[BC_CLK_POL_BIT];
            end
            if (pend_r && ofs_r == OFS_DIV_HIGH) hi_r <= HWDATA[7:0];
            if (pend_r && ofs_r == OFS_DIV_LOW) lo_r <= HWDATA[7:0];
            ok_r <= wr_div ? 1'b1 : (wr_ctl ? 1'b0 : ok_r);
            // The divider reloads n at the write edge, so the first
            // tick after a restart lands one edge later than a reload
            if (wr_div) begin
                cnt_r <= 18'h3_FFFF;
            end else if (SAMPLE_TICK) begin
                cnt_r <= 18'h0_0000;
            end else begin
                cnt_r <= cnt_r + 18'h0_0001;
            end
            if (wr_div || wr_ctl) begin
                stk_r <= 6'h00;
            end else if (SAMPLE_TICK) begin
                stk_r <= BAUD_TICK ? 6'h00 : stk_r + 6'h01;
            end
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    chk_bus_ready: assert property (HREADYOUT)
        else $error("slave inserted a wait state");
    chk_bus_okay: assert property (HRESP == HRESP_OKAY)
        else $error("slave gave an error response");
    chk_tick_spacing:
        assert property (ok_r && SAMPLE_TICK |-> cnt_r == {2'h0, n})
        else $error("sample tick early");
    chk_tick_due:
        assert property (ok_r && cnt_r == {2'h0, n} |-> SAMPLE_TICK)
        else $error("sample tick missing");
    chk_baud_ratio:
        assert property (ok_r && SAMPLE_TICK
            |-> BAUD_TICK == (stk_r == 6'(r - 7'h01)))
        else $error("bit tick off the ratio");
    chk_baud_in_sample:
        assert property (BAUD_TICK |-> SAMPLE_TICK)
        else $error("bit tick without sample tick");
    chk_valid_pulse:
        assert property (RX_LEVEL_VALID |=> !RX_LEVEL_VALID)
        else $error("level valid longer than one cycle");
    chk_level_hold:
        assert property ($changed(RX_LEVEL) |-> RX_LEVEL_VALID)
        else $error("level changed without a vote");
    chk_shift_idle:
        assert property (ok_r && !sync_r |-> SHIFT_CLK == pol_r)
        else $error("shift clock not idle");
    cover property (BAUD_TICK && sync_r);
    cover property (RX_LEVEL_VALID);
    cover property ($rose(SHIFT_CLK));
endmodule
bind baud_gen baud_gen_asserts u_chk (.CLOCK, .RST_B, .HSEL, .HADDR,
    .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT,
    .HRESP, .RECEIVE_PIN, .SAMPLE_TICK, .BAUD_TICK, .SHIFT_CLK,
    .RX_LEVEL, .RX_LEVEL_VALID);

//--- test/testbench.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/1ns
module testbench;
    import baud_pkg::*;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    word_t HADDR = 32'h0000_0000;
    word_t HWDATA = 32'h0000_0000;
    word_t HRDATA;
    logic HREADYOUT, HRESP, RECEIVE_PIN, SAMPLE_TICK, BAUD_TICK;
    logic SHIFT_CLK, RX_LEVEL, RX_LEVEL_VALID;
    logic level = 1'b1;
    logic glitch_en = 1'b0;
    int failures = 0;
    int n_compared = 0;
    int seed = 32'h20ff_2b2a;

    baud_gen u_dut (.CLOCK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE,
        .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
        .RECEIVE_PIN, .SAMPLE_TICK, .BAUD_TICK, .SHIFT_CLK, .RX_LEVEL,
        .RX_LEVEL_VALID);
    serial_station u_station (.clk(CLOCK), .level, .glitch_en,
        .pin(RECEIVE_PIN));

    always #5 CLOCK = ~CLOCK;

    task check(input word_t got, input word_t exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One single transfer: address phase, then data phase
    task bus(input logic w, input logic [2:0] sz, input logic [7:0] a,
        input word_t d, output word_t r);
        int k;
        k = 0;
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HSIZE <= sz;
        HADDR <= {24'h00_0000, a};
        @(posedge CLOCK);
        while (HREADYOUT !== 1'b1 && k < 100) begin
            @(posedge CLOCK);
            k++;
        end
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLOCK);
        while (HREADYOUT !== 1'b1 && k < 100) begin
            @(posedge CLOCK);
            k++;
        end
        r = HRDATA;
        if (k >= 100) failures++;
    endtask

    function logic sig(input int s);
        sig = (s == 0) ? SAMPLE_TICK : ((s == 1) ? BAUD_TICK : SHIFT_CLK);
    endfunction

    // Cycles between two rising edges of the chosen output
    task period(input int s, output int c);
        logic p;
        int e;
        p = 1'b1;
        e = 0;
        c = 0;
        while (e < 2 && c < 20000) begin
            @(posedge CLOCK);
            #1;
            c++;
            if (sig(s) === 1'b1 && p === 1'b0) begin
                e++;
                if (e == 1) c = 0;
            end
            p = sig(s);
        end
    endtask

    // Read-back value after a word write of d
    function word_t rexp(input logic [7:0] a, input word_t d);
        case (a)
            OFS_TX_CTRL: rexp = 32'((d[7:0] & TX_CTRL_WMASK) | TX_CTRL_ONES);
            OFS_RX_CTRL: rexp = 32'(d[7:0] & RX_CTRL_WMASK);
            OFS_BAUD_CTRL: rexp = 32'((d[7:0] & BAUD_CTRL_WMASK)
                | BAUD_CTRL_ONES);
            OFS_DIV_HIGH, OFS_DIV_LOW: rexp = 32'(d[7:0]);
            default: rexp = 32'h0000_0000;
        endcase
    endfunction

    // Sample ticks per bit for {sync, wide, high speed}
    function int ratio(input logic [2:0] m);
        ratio = (m[2] || m[1:0] == 2'h3) ? 4 : ((m[1] || m[0]) ? 16 : 64);
    endfunction

    task print_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the scenarios need roughly 20,000 cycles at worst
    initial begin
        #600_000;
        failures++;
        print_verdict;
    end

    initial begin
        int i, c, nv, e;
        logic [7:0] a, hi, lo;
        logic [2:0] m;
        word_t v, r;
        repeat (10) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        // Reset values, random write and read back, byte write ignored
        for (i = 0; i < 7; i++) begin
            a = 8'(i * 4);
            if (a == OFS_STATUS) continue;
            bus(1'b0, HSIZE_WORD, a, 32'h0000_0000, r);
            check(r, rexp(a, 32'h0000_0000));
            v = $random(seed);
            if (a == OFS_TX_CTRL) v[TX_SYNC_BIT] = 1'b0;
            bus(1'b1, HSIZE_WORD, a, v, r);
            bus(1'b0, HSIZE_WORD, a, 32'h0000_0000, r);
            check(r, rexp(a, v));
            bus(1'b1, 3'h0, a, ~v, r);
            bus(1'b0, HSIZE_WORD, a, 32'h0000_0000, r);
            check(r, rexp(a, v));
        end
        // Every mode with a random divisor: tick, bit and shift periods
        bus(1'b1, HSIZE_WORD, OFS_RX_CTRL, 32'h0000_0080, r);
        for (i = 0; i < 7; i++) begin
            m = 3'(i);
            v = $random(seed);
            lo = v[7:0] % 8'h08 + 8'h02;
            hi = m[1] ? {7'h00, v[8]} : (v[15:8] | 8'h01);
            nv = m[1] ? int'({hi, lo}) : int'(lo);
            bus(1'b1, HSIZE_WORD, OFS_TX_CTRL,
                32'({m[2], 2'h0, m[2], 1'b0, m[0], 2'h0}), r);
            bus(1'b1, HSIZE_WORD, OFS_BAUD_CTRL, 32'({m[1], 3'h0}), r);
            bus(1'b1, HSIZE_WORD, OFS_DIV_HIGH, 32'(hi), r);
            bus(1'b1, HSIZE_WORD, OFS_DIV_LOW, 32'(lo), r);
            period(0, c);
            check(32'(c), 32'(nv + 1));
            period(1, c);
            e = ratio(m) * (nv + 1);
            check(32'(c), 32'(e));
            if (m[2]) begin
                period(2, c);
                check(32'(c), 32'(4 * (nv + 1)));
            end
        end
        // Steady line with one-cycle glitches, then inverted polarity
        bus(1'b1, HSIZE_WORD, OFS_TX_CTRL, 32'h0000_0000, r);
        bus(1'b1, HSIZE_WORD, OFS_BAUD_CTRL, 32'h0000_0000, r);
        bus(1'b1, HSIZE_WORD, OFS_DIV_LOW, 32'h0000_0000, r);
        level <= 1'b0;
        glitch_en <= 1'b1;
        repeat (300) @(posedge CLOCK);
        c = 0;
        repeat (600) begin
            @(posedge CLOCK);
            #1;
            c += int'(RX_LEVEL !== 1'b0);
        end
        check(32'(c), 32'h0000_0000);
        bus(1'b1, HSIZE_WORD, OFS_BAUD_CTRL, 32'h0000_0020, r);
        repeat (300) @(posedge CLOCK);
        check(32'(RX_LEVEL), 32'h0000_0001);
        print_verdict;
    end
endmodule
